// ### core/tcl_count_engine.sv
/*
 * counting engine of one timer: edge-aligned up or down, or center-aligned up and down.
 * assumes a one-cycle count tick from the prescaler and a reload value already selected.
 */
`timescale 1ns/1ns
module tcl_count_engine (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic tick,
    input wire logic reinit,
    input wire tcl_pkg::tcl_align_t align,
    input wire logic dir_down,
    input wire logic [tcl_pkg::TCL_COUNT_W-1:0] reload,
    input wire logic load_count,
    input wire logic [tcl_pkg::TCL_COUNT_W-1:0] load_value,
    output logic [tcl_pkg::TCL_COUNT_W-1:0] count,
    output logic counting_down,
    output logic wrap
);
    import tcl_pkg::*;

    logic [TCL_COUNT_W-1:0] next_count;
    logic next_down;
    logic center;
    logic at_top;
    logic at_bottom;

    assign center = (align != TCL_ALIGN_EDGE);
    assign at_top = (count >= reload);
    assign at_bottom = (count == '0);
    // a wrap is an overflow going up or an underflow going down
    assign wrap = tick && (counting_down ? at_bottom : at_top);

    always_comb begin
        next_count = count;
        next_down = counting_down;
        if (reinit) begin
            // edge-aligned down restarts from reload, every other mode from zero
            next_count = (!center && dir_down) ? reload : '0;
            next_down = !center && dir_down;
        end else if (load_count) begin
            next_count = load_value;
        end else if (tick) begin
            if (!center) begin
                next_down = dir_down;
                if (dir_down) begin
                    next_count = at_bottom ? reload : count - 1'b1;
                end else begin
                    next_count = at_top ? '0 : count + 1'b1;
                end
            end else if (counting_down) begin
                // turning at the ends keeps the triangle symmetric
                if (at_bottom) begin
                    next_down = 1'b0;
                    next_count = (reload == '0) ? '0 : TCL_COUNT_W'(1);
                end else begin
                    next_count = count - 1'b1;
                end
            end else if (at_top) begin
                next_down = 1'b1;
                next_count = (reload == '0) ? '0 : reload - 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            count <= TCL_COUNT_RESET;
            counting_down <= 1'b0;
        end else begin
            count <= next_count;
            counting_down <= next_down;
        end
    end

endmodule : tcl_count_engine

// ### core/tcl_timer_pair.sv
/*
 * control logic of two identical general purpose timers behind one register port: counter
 * enable, direction, alignment modes, one pulse, reload buffering, update events and requests.
 * assumes trigger and slave reset inputs come from logic on the same clock, and that compare
 * channels use the qualifier and update outputs to gate their flags and load their shadows.
 */
`timescale 1ns/1ns
module tcl_timer_pair (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic [31:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    output logic [31:0] REG_RDATA,
    input wire logic [1:0] TRIGGER_START,
    input wire logic [1:0] SLAVE_RESET,
    output logic [1:0] UPDATE_EVENT,
    output logic [1:0] UPDATE_REQUEST,
    output logic [1:0] COMPARE_FLAG_ALLOW,
    output logic [1:0] COUNTER_RUNNING,
    output logic [31:0] COUNT_VALUE_ONE,
    output logic [31:0] COUNT_VALUE_TWO
);
    import tcl_pkg::*;

    // -----------------------------------------------------------------
    // address decode helpers
    // -----------------------------------------------------------------
    function automatic logic in_block(input logic [31:0] addr, input logic [31:0] base);
        in_block = (addr[31:12] == base[31:12]);
    endfunction : in_block

    function automatic logic hits(input logic [31:0] addr, input logic [31:0] base,
                                  input logic [11:0] ofs);
        hits = in_block(addr, base) && (addr[11:0] == ofs);
    endfunction : hits

    localparam logic [31:0] BASES [2] = '{TCL_BASE_ONE, TCL_BASE_TWO};

    logic [31:0] read_word [2];
    logic [1:0] read_hit;
    logic [31:0] next_rdata;
    logic [TCL_COUNT_W-1:0] count_out [2];

    // -----------------------------------------------------------------
    // one timer per base address, identical in all else
    // -----------------------------------------------------------------
    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_timer
            logic wr_control_a;
            logic wr_control_b;
            logic wr_event;
            logic wr_count;
            logic wr_prescaler;
            logic wr_reload;

            logic reload_buffer_enable;
            tcl_align_t alignment_mode_select;
            logic count_direction;
            logic one_pulse_select;
            logic update_request_source;
            logic update_disable;
            logic counter_enable_bit;
            logic [3:0] control_b;

            logic [TCL_COUNT_W-1:0] reload_written;
            logic [TCL_COUNT_W-1:0] reload_shadow;
            logic [TCL_COUNT_W-1:0] reload_active;
            logic [TCL_COUNT_W-1:0] prescaler_written;
            logic [TCL_COUNT_W-1:0] prescaler_shadow;
            logic [TCL_COUNT_W-1:0] prescale_count;
            logic [TCL_COUNT_W-1:0] count;

            logic sw_update;
            logic reinit;
            logic tick;
            logic wrap;
            logic counting_down;
            logic update_event;
            logic update_request;
            logic opm_stop;
            logic dir_read;
            logic compare_allow;
            logic next_enable;

            assign wr_control_a = REG_WRITE && hits(REG_ADDR, BASES[t], TCL_OFS_CONTROL_A);
            assign wr_control_b = REG_WRITE && hits(REG_ADDR, BASES[t], TCL_OFS_CONTROL_B);
            assign wr_event = REG_WRITE && hits(REG_ADDR, BASES[t], TCL_OFS_EVENT_GEN);
            assign wr_count = REG_WRITE && hits(REG_ADDR, BASES[t], TCL_OFS_COUNT);
            assign wr_prescaler = REG_WRITE && hits(REG_ADDR, BASES[t], TCL_OFS_PRESCALER);
            assign wr_reload = REG_WRITE && hits(REG_ADDR, BASES[t], TCL_OFS_RELOAD);

            // -----------------------------------------------------------------
            // update sources
            // -----------------------------------------------------------------
            assign sw_update = wr_event && REG_WDATA[TCL_BIT_UPDATE_GENERATE];
            // software and slave resets restart counter and prescaler even when updates are off
            assign reinit = sw_update || SLAVE_RESET[t];
            // wraps, software and slave resets make an update unless updates are disabled
            assign update_event = !update_disable && (wrap || reinit);
            // the request source bit filters out software and slave updates
            assign update_request = update_event
                && (!update_request_source || wrap);
            assign opm_stop = one_pulse_select && update_event;

            // buffered reload waits for the shadow, unbuffered takes the written value at once
            assign reload_active = reload_buffer_enable ? reload_shadow : reload_written;

            // prescaler divides only while enabled, so the counter stands still otherwise
            assign tick = counter_enable_bit && (prescale_count >= prescaler_shadow);

            // compare flag qualifier per alignment mode
            assign compare_allow = (alignment_mode_select == TCL_ALIGN_EDGE)
                || (alignment_mode_select == TCL_ALIGN_CENTER_BOTH)
                || (alignment_mode_select == TCL_ALIGN_CENTER_DOWN && counting_down)
                || (alignment_mode_select == TCL_ALIGN_CENTER_UP && !counting_down);

            // in center modes the direction bit shows the running direction
            assign dir_read = (alignment_mode_select == TCL_ALIGN_EDGE) ? count_direction : counting_down;

            // trigger set wins over both a software clear and a one pulse stop
            assign next_enable = TRIGGER_START[t] ? 1'b1
                : wr_control_a ? REG_WDATA[TCL_BIT_COUNTER_ENABLE]
                : opm_stop ? 1'b0 : counter_enable_bit;

            tcl_count_engine u_engine (
                .CORE_CLK(CORE_CLK),
                .RESET(RESET),
                .tick(tick),
                .reinit(reinit),
                .align(alignment_mode_select),
                .dir_down(count_direction),
                .reload(reload_active),
                .load_count(wr_count),
                .load_value(REG_WDATA[TCL_COUNT_W-1:0]),
                .count(count),
                .counting_down(counting_down),
                .wrap(wrap)
            );

            // -----------------------------------------------------------------
            // control registers
            // -----------------------------------------------------------------
            always_ff @(posedge CORE_CLK or posedge RESET) begin
                if (RESET) begin
                    reload_buffer_enable <= TCL_CONTROL_A_RESET[TCL_BIT_RELOAD_BUFFER_ENABLE];
                    alignment_mode_select <= tcl_align_t'(TCL_CONTROL_A_RESET[TCL_BIT_ALIGN_HI:TCL_BIT_ALIGN_LO]);
                    count_direction <= TCL_CONTROL_A_RESET[TCL_BIT_COUNT_DIRECTION];
                    one_pulse_select <= TCL_CONTROL_A_RESET[TCL_BIT_ONE_PULSE];
                    update_request_source <= TCL_CONTROL_A_RESET[TCL_BIT_UPDATE_REQUEST_SOURCE];
                    update_disable <= TCL_CONTROL_A_RESET[TCL_BIT_UPDATE_DISABLE];
                end else if (wr_control_a) begin
                    reload_buffer_enable <= REG_WDATA[TCL_BIT_RELOAD_BUFFER_ENABLE];
                    alignment_mode_select <= tcl_align_t'(REG_WDATA[TCL_BIT_ALIGN_HI:TCL_BIT_ALIGN_LO]);
                    count_direction <= REG_WDATA[TCL_BIT_COUNT_DIRECTION];
                    one_pulse_select <= REG_WDATA[TCL_BIT_ONE_PULSE];
                    update_request_source <= REG_WDATA[TCL_BIT_UPDATE_REQUEST_SOURCE];
                    update_disable <= REG_WDATA[TCL_BIT_UPDATE_DISABLE];
                end
            end

            always_ff @(posedge CORE_CLK or posedge RESET) begin
                if (RESET) begin
                    counter_enable_bit <= TCL_CONTROL_A_RESET[TCL_BIT_COUNTER_ENABLE];
                end else begin
                    counter_enable_bit <= next_enable;
                end
            end

            always_ff @(posedge CORE_CLK or posedge RESET) begin
                if (RESET) begin
                    control_b <= TCL_CONTROL_B_RESET;
                end else if (wr_control_b) begin
                    control_b <= REG_WDATA[TCL_CONTROL_B_HI:TCL_CONTROL_B_LO];
                end
            end

            // -----------------------------------------------------------------
            // reload and prescaler buffers with their shadows
            // -----------------------------------------------------------------
            always_ff @(posedge CORE_CLK or posedge RESET) begin
                if (RESET) begin
                    reload_written <= TCL_RELOAD_RESET;
                    prescaler_written <= TCL_PRESCALER_RESET;
                end else begin
                    if (wr_reload) begin
                        reload_written <= REG_WDATA[TCL_COUNT_W-1:0];
                    end
                    if (wr_prescaler) begin
                        prescaler_written <= REG_WDATA[TCL_COUNT_W-1:0];
                    end
                end
            end

            always_ff @(posedge CORE_CLK or posedge RESET) begin
                if (RESET) begin
                    reload_shadow <= TCL_RELOAD_RESET;
                    prescaler_shadow <= TCL_PRESCALER_RESET;
                end else if (update_event) begin
                    reload_shadow <= reload_written;
                    prescaler_shadow <= prescaler_written;
                end
            end

            always_ff @(posedge CORE_CLK or posedge RESET) begin
                if (RESET) begin
                    prescale_count <= '0;
                end else if (reinit || tick) begin
                    prescale_count <= '0;
                end else if (counter_enable_bit) begin
                    prescale_count <= prescale_count + 1'b1;
                end
            end

            // -----------------------------------------------------------------
            // outputs and read back
            // -----------------------------------------------------------------
            always_ff @(posedge CORE_CLK or posedge RESET) begin
                if (RESET) begin
                    UPDATE_EVENT[t] <= 1'b0;
                    UPDATE_REQUEST[t] <= 1'b0;
                    COMPARE_FLAG_ALLOW[t] <= 1'b1;
                end else begin
                    UPDATE_EVENT[t] <= update_event;
                    UPDATE_REQUEST[t] <= update_request;
                    COMPARE_FLAG_ALLOW[t] <= compare_allow;
                end
            end

            assign COUNTER_RUNNING[t] = counter_enable_bit;
            assign count_out[t] = count;

            // bits above the defined fields read as zero
            assign read_hit[t] = REG_READ && in_block(REG_ADDR, BASES[t]);
            assign read_word[t] =
                (REG_ADDR[11:0] == TCL_OFS_CONTROL_A) ? {24'h000000, reload_buffer_enable,
                    alignment_mode_select, dir_read, one_pulse_select, update_request_source,
                    update_disable, counter_enable_bit}
                : (REG_ADDR[11:0] == TCL_OFS_CONTROL_B) ? {24'h000000, control_b, 4'h0}
                : (REG_ADDR[11:0] == TCL_OFS_COUNT) ? {16'h0000, count}
                : (REG_ADDR[11:0] == TCL_OFS_PRESCALER) ? {16'h0000, prescaler_written}
                : (REG_ADDR[11:0] == TCL_OFS_RELOAD) ? {16'h0000, reload_written}
                : 32'h00000000;
        end
    endgenerate

    // -----------------------------------------------------------------
    // register read port: data stand for one cycle, zero otherwise
    // -----------------------------------------------------------------
    assign next_rdata = read_hit[0] ? read_word[0]
        : read_hit[1] ? read_word[1] : 32'h00000000;

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            REG_RDATA <= 32'h00000000;
        end else begin
            REG_RDATA <= next_rdata;
        end
    end

    assign COUNT_VALUE_ONE = {16'h0000, count_out[0]};
    assign COUNT_VALUE_TWO = {16'h0000, count_out[1]};

endmodule : tcl_timer_pair

// ### inc/tcl_pkg.sv
/*
 * constants shared by the dual timer control block: register map, field positions, reset values
 * and the alignment mode encoding.
 * assumes a single 125 MHz core clock and a plain strobe register port with 32-bit byte addresses.
 */
// Summary of operation
// - reload buffer bit defers reload until update
// - mode 00 counts edge-aligned per direction
// - mode 01 alternates, compares only counting down
// - mode 10 alternates, compares only counting up
// - mode 11 alternates, compares both directions
// - direction 0 counts up, 1 down
// - one pulse stops counter, clears enable
// - request source 0: every update requests
// - request source 1: only over/underflow requests
// - update loads shadows on wrap, software, slave
// - update disable keeps shadows, still reinitialises
// - counter runs only while enable set
// - trigger mode sets enable in hardware
// - control register resets zero, upper bits zero
package tcl_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [31:0] TCL_BASE_ONE = 32'h4000e000;
    localparam logic [31:0] TCL_BASE_TWO = 32'h4000f000;
    localparam logic [11:0] TCL_OFS_CONTROL_A = 12'h000;
    localparam logic [11:0] TCL_OFS_CONTROL_B = 12'h004;
    localparam logic [11:0] TCL_OFS_EVENT_GEN = 12'h014;
    localparam logic [11:0] TCL_OFS_COUNT = 12'h024;
    localparam logic [11:0] TCL_OFS_PRESCALER = 12'h028;
    localparam logic [11:0] TCL_OFS_RELOAD = 12'h02c;

    // -----------------------------------------------------------------
    // timer_control_a fields
    // -----------------------------------------------------------------
    localparam int TCL_BIT_RELOAD_BUFFER_ENABLE = 7;
    localparam int TCL_BIT_ALIGN_HI = 6;
    localparam int TCL_BIT_ALIGN_LO = 5;
    localparam int TCL_BIT_COUNT_DIRECTION = 4;
    localparam int TCL_BIT_ONE_PULSE = 3;
    localparam int TCL_BIT_UPDATE_REQUEST_SOURCE = 2;
    localparam int TCL_BIT_UPDATE_DISABLE = 1;
    localparam int TCL_BIT_COUNTER_ENABLE = 0;
    localparam logic [7:0] TCL_CONTROL_A_RESET = 8'h00;

    // -----------------------------------------------------------------
    // timer_control_b fields: only stored and read back here
    // -----------------------------------------------------------------
    localparam int TCL_CONTROL_B_HI = 7;
    localparam int TCL_CONTROL_B_LO = 4;
    localparam logic [3:0] TCL_CONTROL_B_RESET = 4'h0;

    // event generation register: bit 0 is the update generate bit
    localparam int TCL_BIT_UPDATE_GENERATE = 0;

    // -----------------------------------------------------------------
    // counter widths and reset values
    // -----------------------------------------------------------------
    localparam int TCL_COUNT_W = 16;
    localparam logic [15:0] TCL_RELOAD_RESET = 16'hffff;
    localparam logic [15:0] TCL_PRESCALER_RESET = 16'h0000;
    localparam logic [15:0] TCL_COUNT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        TCL_ALIGN_EDGE = 2'h0,
        TCL_ALIGN_CENTER_DOWN = 2'h1,
        TCL_ALIGN_CENTER_UP = 2'h2,
        TCL_ALIGN_CENTER_BOTH = 2'h3
    } tcl_align_t;

endpackage : tcl_pkg

// ### sim/tb_tcl_timer_pair.sv
/* self-checking bench for the dual timer control pair, both timers in turn.
   assumes the package is compiled first and the monitor file binds itself to the pair. */
`timescale 1ns/1ns
module tb_tcl_timer_pair;
    import tcl_pkg::*;
    logic CORE_CLK = 1'b0, RESET = 1'b1, REG_WRITE = 1'b0, REG_READ = 1'b0, rd_d = 1'b0, tsel = 1'b0, ck_on = 1'b0;
    logic [31:0] REG_ADDR = 32'h0, REG_WDATA = 32'h0;
    logic [1:0] TRIGGER_START = 2'h0, SLAVE_RESET = 2'h0;
    logic [31:0] REG_RDATA, COUNT_VALUE_ONE, COUNT_VALUE_TWO, cnt, r;
    logic [1:0] UPDATE_EVENT, UPDATE_REQUEST, COMPARE_FLAG_ALLOW, COUNTER_RUNNING, cmode;
    logic [31:0] exp_q[$];
    logic [15:0] cmax, prev;
    int n_mismatch = 0, compares = 0, cyc = 0, n_uev, n_req;
    tcl_timer_pair tcl_timer_pair_inst (.CORE_CLK(CORE_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA),
        .TRIGGER_START(TRIGGER_START), .SLAVE_RESET(SLAVE_RESET), .UPDATE_EVENT(UPDATE_EVENT),
        .UPDATE_REQUEST(UPDATE_REQUEST), .COMPARE_FLAG_ALLOW(COMPARE_FLAG_ALLOW), .COUNTER_RUNNING(COUNTER_RUNNING),
        .COUNT_VALUE_ONE(COUNT_VALUE_ONE), .COUNT_VALUE_TWO(COUNT_VALUE_TWO));
    assign cnt = tsel ? COUNT_VALUE_TWO : COUNT_VALUE_ONE;
    initial begin
        forever #4 CORE_CLK = ~CORE_CLK;
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic final_report();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic acc(input logic wr_n, input logic [11:0] ofs, input logic [31:0] d);
        @(posedge CORE_CLK);
        if (wr_n) REG_READ <= 1'b1;
        else REG_WRITE <= 1'b1;
        REG_ADDR <= (tsel ? TCL_BASE_TWO : TCL_BASE_ONE) + {20'h0, ofs};
        REG_WDATA <= d;
        @(posedge CORE_CLK);
        REG_READ <= 1'b0;
        REG_WRITE <= 1'b0;
    endtask : acc
    task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
        acc(1'b0, ofs, d);
    endtask : wr
    task automatic rd(input logic [11:0] ofs, input logic [31:0] exp);
        exp_q.push_back(exp);
        acc(1'b1, ofs, 32'h0);
    endtask : rd
    task automatic pulse(input logic trig);
        @(posedge CORE_CLK);
        if (trig) TRIGGER_START <= 2'h1 << tsel;
        else SLAVE_RESET <= 2'h1 << tsel;
        @(posedge CORE_CLK);
        TRIGGER_START <= 2'h0;
        SLAVE_RESET <= 2'h0;
    endtask : pulse
    task automatic clr();
        @(negedge CORE_CLK);
        n_uev = 0;
        n_req = 0;
        cmax = 16'h0;
    endtask : clr
    // settle first so a count left over from the old reload stays out of the window
    task automatic win(input int n);
        repeat (10) @(posedge CORE_CLK);
        clr();
        repeat (n) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
    endtask : win
    // watcher: read data one cycle after the strobe, event counts, peak count, compare qualifier
    always @(posedge CORE_CLK) begin
        if (rd_d) cmp(REG_RDATA, exp_q.pop_front());
        rd_d <= REG_READ;
        n_uev <= n_uev + UPDATE_EVENT[tsel];
        n_req <= n_req + UPDATE_REQUEST[tsel];
        if (cnt[15:0] > cmax) cmax <= cnt[15:0];
        if (ck_on && cnt[15:0] inside {[2:5]} && prev inside {[2:5]} && cnt[15:0] != prev)
            cmp(32'(COMPARE_FLAG_ALLOW[tsel]),
                32'(cmode == 0 || cmode == 3 || (cmode == 1) == (cnt[15:0] < prev)));
        prev <= cnt[15:0];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        void'($urandom(25));
        repeat (5) @(posedge CORE_CLK);
        RESET <= 1'b0;
        for (int t = 0; t < 2; t++) begin
            tsel = t[0];
            rd(TCL_OFS_CONTROL_A, 32'h0);
            rd(TCL_OFS_CONTROL_B, 32'h0);
            rd(TCL_OFS_RELOAD, 32'hffff);
            rd(12'h100, 32'h0);
            r = $urandom;
            wr(TCL_OFS_CONTROL_A, {r[31:8], 8'h86});
            rd(TCL_OFS_CONTROL_A, 32'h86);
            wr(TCL_OFS_CONTROL_B, r);
            rd(TCL_OFS_CONTROL_B, {24'h0, r[7:4], 4'h0});
            $display("timer %0d registers done", t);
            wr(TCL_OFS_RELOAD, 32'h3);
            for (int k = 0; k < 6; k++) begin
                wr(TCL_OFS_CONTROL_A, k < 2 ? 32'h0 : (k < 4 ? 32'h4 : 32'h2));
                wr(TCL_OFS_COUNT, 32'h5);
                clr();
                if (k[0]) pulse(1'b0);
                else wr(TCL_OFS_EVENT_GEN, 32'h1);
                rd(TCL_OFS_COUNT, 32'h0);
                repeat (2) @(posedge CORE_CLK);
                @(negedge CORE_CLK);
                cmp(n_uev, k < 4);
                cmp(n_req, k < 2);
            end
            wr(TCL_OFS_CONTROL_A, 32'h10);
            wr(TCL_OFS_EVENT_GEN, 32'h1);
            rd(TCL_OFS_COUNT, 32'h3);
            $display("timer %0d update events done", t);
            wr(TCL_OFS_CONTROL_A, 32'h5);
            win(30);
            cmp(cmax, 16'h3);
            cmp(32'(n_req > 6), 32'h1);
            wr(TCL_OFS_CONTROL_A, 32'h83);
            wr(TCL_OFS_RELOAD, 32'h7);
            win(30);
            cmp(cmax, 16'h3);
            cmp(n_uev, 0);
            wr(TCL_OFS_CONTROL_A, 32'h81);
            win(30);
            cmp(cmax, 16'h7);
            wr(TCL_OFS_CONTROL_A, 32'h1);
            wr(TCL_OFS_RELOAD, 32'h5);
            win(30);
            cmp(cmax, 16'h5);
            wr(TCL_OFS_CONTROL_A, 32'h0);
            win(20);
            cmp(n_uev, 0);
            $display("timer %0d counting done", t);
            for (int m = 0; m < 4; m++) begin
                cmode = m[1:0];
                wr(TCL_OFS_CONTROL_A, {25'h0, m[1:0], 5'h0});
                wr(TCL_OFS_RELOAD, 32'h7);
                wr(TCL_OFS_EVENT_GEN, 32'h1);
                wr(TCL_OFS_CONTROL_A, {25'h0, m[1:0], 5'h1});
                ck_on = 1'b1;
                win(40);
                ck_on = 1'b0;
                cmp(cmax, 16'h7);
                wr(TCL_OFS_CONTROL_A, 32'h0);
            end
            $display("timer %0d alignment modes done", t);
            wr(TCL_OFS_EVENT_GEN, 32'h1);
            wr(TCL_OFS_CONTROL_A, 32'h9);
            repeat (20) @(posedge CORE_CLK);
            rd(TCL_OFS_CONTROL_A, 32'h8);
            wr(TCL_OFS_CONTROL_A, 32'h0);
            pulse(1'b1);
            rd(TCL_OFS_CONTROL_A, 32'h1);
            wr(TCL_OFS_CONTROL_A, 32'h0);
            $display("timer %0d one pulse and trigger done", t);
        end
        repeat (4) @(posedge CORE_CLK);
        final_report();
    end
endmodule : tb_tcl_timer_pair

// ### sim/tcl_pair_monitor.sv
/* concurrent checks on the ports of the dual timer control pair.
   assumes one core clock, an active high asynchronous reset and a bind to tcl_timer_pair. */
`timescale 1ns/1ns
module tcl_pair_monitor (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic [31:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    input wire logic [31:0] REG_RDATA,
    input wire logic [1:0] TRIGGER_START,
    input wire logic [1:0] SLAVE_RESET,
    input wire logic [1:0] UPDATE_EVENT,
    input wire logic [1:0] UPDATE_REQUEST,
    input wire logic [1:0] COMPARE_FLAG_ALLOW,
    input wire logic [1:0] COUNTER_RUNNING,
    input wire logic [31:0] COUNT_VALUE_ONE,
    input wire logic [31:0] COUNT_VALUE_TWO
);
    import tcl_pkg::*;
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking mon_cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);
    chk_rdata_idle: assert property (!REG_READ |=> REG_RDATA == 32'h0)
        else $error("read data outside a read");
    chk_req_event_one: assert property (UPDATE_REQUEST[0] |-> UPDATE_EVENT[0])
        else $error("timer one request without update");
    chk_req_event_two: assert property (UPDATE_REQUEST[1] |-> UPDATE_EVENT[1])
        else $error("timer two request without update");
    chk_trigger_one: assert property (TRIGGER_START[0] |=> COUNTER_RUNNING[0])
        else $error("timer one trigger did not enable");
    chk_trigger_two: assert property (TRIGGER_START[1] |=> COUNTER_RUNNING[1])
        else $error("timer two trigger did not enable");
    // writes and slave resets may legally move a stopped counter, so they are kept out
    chk_hold_one: assert property (!COUNTER_RUNNING[0] && !REG_WRITE && !$past(REG_WRITE)
        && !SLAVE_RESET[0] && !$past(SLAVE_RESET[0]) |=> $stable(COUNT_VALUE_ONE)) else $error("count one moved");
    chk_hold_two: assert property (!COUNTER_RUNNING[1] && !REG_WRITE && !$past(REG_WRITE)
        && !SLAVE_RESET[1] && !$past(SLAVE_RESET[1]) |=> $stable(COUNT_VALUE_TWO)) else $error("count two moved");
    chk_count_upper: assert property ({COUNT_VALUE_ONE[31:16], COUNT_VALUE_TWO[31:16]} == 32'h0)
        else $error("count upper bits not zero");
endmodule : tcl_pair_monitor

bind tcl_timer_pair tcl_pair_monitor tcl_pair_monitor_inst (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA),
    .TRIGGER_START(TRIGGER_START), .SLAVE_RESET(SLAVE_RESET), .UPDATE_EVENT(UPDATE_EVENT),
    .UPDATE_REQUEST(UPDATE_REQUEST), .COMPARE_FLAG_ALLOW(COMPARE_FLAG_ALLOW), .COUNTER_RUNNING(COUNTER_RUNNING),
    .COUNT_VALUE_ONE(COUNT_VALUE_ONE), .COUNT_VALUE_TWO(COUNT_VALUE_TWO));
